/* acr_aux_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module acr_aux_regs #(
  parameter int SLOW_DIV = acr_pkg::ACR_SLOW_DIV
) (
  input wire logic i_clk, // 20 MHz system clock
  input wire logic i_nrst, // Async reset, active low
  input wire acr_pkg::acr_sfr_req_t i_sfr, // SFR bus request
  output logic [7:0] o_sfr_rdata, // Read data, cycle after rd
  input wire logic i_rc_is_sys_clock, // Internal RC clocks the system
  input wire logic i_osc_tick, // Internal oscillator half-period
  input wire logic i_gpio_o, // GPIO value for crystal pin
  input wire logic i_gpio_oe, // GPIO drive for crystal pin
  input wire logic i_t0_timer_mode, // Timer 0 in timer mode
  input wire logic i_t1_timer_mode, // Timer 1 in timer mode
  output logic o_xtal_pin_o, // Crystal output pin value
  output logic o_xtal_pin_oe, // Crystal output pin drive
  output logic o_xtal_osc_role, // Crystal pins act as oscillator
  output acr_pkg::acr_ctrl_t o_ctrl, // Decoded control levels
  output logic o_t0_tick, // Timer 0 count enable
  output logic o_t1_tick, // Timer 1 count enable
  output logic o_urm0_tick // Serial mode 0 shift enable
);
  import acr_pkg::*;

  if (SLOW_DIV < 2 || SLOW_DIV > 255)
  begin : g_bad_div
    $error("SLOW_DIV out of range");
  end

  logic rst_s1_r;
  logic rst_n_r;
  logic [7:0] speed_r;
  logic [7:0] pinclk_r;
  logic [7:0] route_r;
  logic [7:0] pre_r;
  logic pre_tick;
  logic half_r;
  logic [2:0] osc_cnt_r;
  logic xtal_out;
  acr_xsel_t xsel;
  logic [3:0] wake_oh;
  logic [7:0] t0_gap_r;
  logic [7:0] t0_run_r;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // No page decode: every page sees these addresses
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      speed_r <= ACR_SPEED_RST; // see R16
      pinclk_r <= ACR_PINCLK_RST; // see R16
      route_r <= ACR_ROUTE_RST; // see R16
    end
    else if (i_sfr.wr)
    begin
      // Whole byte stored, reserved bits too
      unique case (i_sfr.addr)
        ACR_SPEED_ADDR: speed_r <= i_sfr.wdata; // see R17
        ACR_PINCLK_ADDR: pinclk_r <= i_sfr.wdata; // see R17
        ACR_ROUTE_ADDR: route_r <= i_sfr.wdata; // see R9
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      o_sfr_rdata <= 8'h00;
    else if (i_sfr.rd)
    begin
      unique case (i_sfr.addr)
        ACR_SPEED_ADDR: o_sfr_rdata <= speed_r; // see R16
        ACR_PINCLK_ADDR: o_sfr_rdata <= pinclk_r;
        ACR_ROUTE_ADDR: o_sfr_rdata <= route_r;
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  assign xsel = acr_xsel_t'(pinclk_r[ACR_XSEL_LO +: 2]);

  // Divider on the oscillator half-period ticks
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      osc_cnt_r <= 3'h0;
    else if (i_osc_tick)
      osc_cnt_r <= osc_cnt_r + 3'h1;
  end

  always_comb
  begin
    unique case (xsel)
      ACR_X_GPIO: xtal_out = i_gpio_o;
      ACR_X_OSC: xtal_out = osc_cnt_r[0]; // see R1
      ACR_X_DIV2: xtal_out = osc_cnt_r[1]; // see R1
      ACR_X_DIV4: xtal_out = osc_cnt_r[2]; // see R1
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_xtal_pin_o <= 1'b0;
      o_xtal_pin_oe <= 1'b0;
      o_xtal_osc_role <= 1'b0;
    end
    else if (!i_rc_is_sys_clock)
    begin
      // Crystal in use: field ignored, pin left to the oscillator
      o_xtal_pin_o <= 1'b0; // see R2
      o_xtal_pin_oe <= 1'b0; // see R2
      o_xtal_osc_role <= 1'b1; // see R2
    end
    else
    begin
      o_xtal_pin_o <= xtal_out; // see R1
      o_xtal_pin_oe <= (xsel == ACR_X_GPIO) ? i_gpio_oe : 1'b1; // see R1
      o_xtal_osc_role <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (route_r[ACR_WAKE_LO +: 2])
      2'b00: wake_oh = 4'h1; // see R6
      2'b01: wake_oh = 4'h2; // see R6
      2'b10: wake_oh = 4'h4; // see R6
      2'b11: wake_oh = 4'h8; // see R6
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      o_ctrl <= '0;
    else
    begin
      o_ctrl.osc_pin_fast_drive <= pinclk_r[ACR_OSC_FD]; // see R3
      o_ctrl.timer0_pin_fast_drive <= pinclk_r[ACR_T0_FD]; // see R4
      o_ctrl.expanded_ram_enable <= !pinclk_r[ACR_ERAM_DIS]; // see R5
      o_ctrl.wake_port_onehot <= wake_oh; // see R6
      o_ctrl.pwm_relocate_upper_port <= route_r[ACR_PWM_UP]; // see R7
      o_ctrl.serial_pin_swap <= route_r[ACR_SER_SWAP]; // see R8
      o_ctrl.data_pointer_select <= route_r[ACR_DP_SEL]; // see R10
      o_ctrl.timer1_clock_out_enable <= speed_r[ACR_T1_CKOE]; // see R14
      o_ctrl.timer0_clock_out_enable <= speed_r[ACR_T0_CKOE]; // see R15
    end
  end

  // Shared divide-by-12 prescaler; free running so rate changes are glitch free
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      pre_r <= 8'h00;
    else if (pre_tick)
      pre_r <= 8'h00;
    else
      pre_r <= pre_r + 8'h01;
  end

  assign pre_tick = (pre_r == 8'(SLOW_DIV - 1));

  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      half_r <= 1'b0;
    else
      half_r <= !half_r;
  end

  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_t0_tick <= 1'b0;
      o_t1_tick <= 1'b0;
      o_urm0_tick <= 1'b0;
    end
    else
    begin
      // Counter mode counts pin events, not these ticks
      o_t0_tick <= i_t0_timer_mode &&
        (speed_r[ACR_T0_FAST] || pre_tick); // see R11
      o_t1_tick <= i_t1_timer_mode &&
        (speed_r[ACR_T1_FAST] || pre_tick); // see R12
      o_urm0_tick <= speed_r[ACR_URM0_FAST] ? half_r : pre_tick; // see R13
    end
  end

  // Checker helpers: counters instead of long repetitions keep the checks cheap
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      t0_gap_r <= 8'h00;
      t0_run_r <= 8'h00;
    end
    else
    begin
      if (o_t0_tick)
        t0_gap_r <= 8'h00;
      else if (t0_gap_r != '1)
        t0_gap_r <= t0_gap_r + 8'h01;
      if (!i_t0_timer_mode || speed_r[ACR_T0_FAST])
        t0_run_r <= 8'h00;
      else if (t0_run_r != '1)
        t0_run_r <= t0_run_r + 8'h01;
    end
  end

  // Checks
  property p_rd_speed;
    @(posedge i_clk) disable iff (!rst_n_r)
    i_sfr.rd && !i_sfr.wr && i_sfr.addr == ACR_SPEED_ADDR
      |=> o_sfr_rdata == $past(speed_r);
  endproperty
  a_rd_speed: assert property (p_rd_speed) // see R16
    else $error("speed register read mismatch");

  property p_wr_rd_route;
    @(posedge i_clk) disable iff (!rst_n_r)
    i_sfr.wr && !i_sfr.rd && i_sfr.addr == ACR_ROUTE_ADDR ##1
      i_sfr.rd && !i_sfr.wr && i_sfr.addr == ACR_ROUTE_ADDR
      |=> o_sfr_rdata == $past(i_sfr.wdata, 2);
  endproperty
  a_wr_rd_route: assert property (p_wr_rd_route) // see R9
    else $error("routing register readback mismatch");

  property p_rd_unmapped;
    @(posedge i_clk) disable iff (!rst_n_r)
    i_sfr.rd && i_sfr.addr != ACR_SPEED_ADDR &&
      i_sfr.addr != ACR_PINCLK_ADDR && i_sfr.addr != ACR_ROUTE_ADDR
      |=> o_sfr_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) // see R17
    else $error("unmapped read not zero");

  property p_xtal_ignored;
    @(posedge i_clk) disable iff (!rst_n_r)
    rst_n_r && !i_rc_is_sys_clock |=> o_xtal_osc_role && !o_xtal_pin_oe;
  endproperty
  a_xtal_ignored: assert property (p_xtal_ignored) // see R2
    else $error("crystal pin driven while crystal in use");

  property p_xtal_div4;
    @(posedge i_clk) disable iff (!rst_n_r)
    rst_n_r && i_rc_is_sys_clock && xsel == ACR_X_DIV4
      |=> o_xtal_pin_oe && o_xtal_pin_o == $past(osc_cnt_r[2]);
  endproperty
  a_xtal_div4: assert property (p_xtal_div4) // see R1
    else $error("crystal pin divide by four wrong");

  property p_xtal_gpio;
    @(posedge i_clk) disable iff (!rst_n_r)
    rst_n_r && i_rc_is_sys_clock && xsel == ACR_X_GPIO
      |=> o_xtal_pin_oe == $past(i_gpio_oe);
  endproperty
  a_xtal_gpio: assert property (p_xtal_gpio) // see R1
    else $error("crystal pin GPIO drive wrong");

  property p_eram;
    @(posedge i_clk) disable iff (!rst_n_r)
    rst_n_r |=> o_ctrl.expanded_ram_enable == !$past(pinclk_r[ACR_ERAM_DIS]);
  endproperty
  a_eram: assert property (p_eram) // see R5
    else $error("expanded RAM enable wrong");

  property p_wake;
    @(posedge i_clk) disable iff (!rst_n_r)
    route_r[ACR_WAKE_LO +: 2] == 2'b10 |=> o_ctrl.wake_port_onehot == 4'h4;
  endproperty
  a_wake: assert property (p_wake) // see R6
    else $error("wakeup port select wrong");

  property p_dp_sel;
    @(posedge i_clk) disable iff (!rst_n_r)
    ##1 o_ctrl.data_pointer_select == $past(route_r[ACR_DP_SEL]);
  endproperty
  a_dp_sel: assert property (p_dp_sel) // see R10
    else $error("data pointer select wrong");

  sequence s_t0_slow_run;
    i_t0_timer_mode && !speed_r[ACR_T0_FAST];
  endsequence
  sequence s_t0_slow_tick;
    o_t0_tick && int'(t0_run_r) > SLOW_DIV;
  endsequence
  property p_t0_slow;
    @(posedge i_clk) disable iff (!rst_n_r)
    s_t0_slow_run ##1 s_t0_slow_tick |-> t0_gap_r == 8'(SLOW_DIV - 1);
  endproperty
  a_t0_slow: assert property (p_t0_slow) // see R11
    else $error("timer 0 slow tick too frequent");

  property p_t1_fast;
    @(posedge i_clk) disable iff (!rst_n_r)
    i_t1_timer_mode && speed_r[ACR_T1_FAST] |=> o_t1_tick;
  endproperty
  a_t1_fast: assert property (p_t1_fast) // see R12
    else $error("timer 1 fast tick missing");

  property p_urm0_fast;
    @(posedge i_clk) disable iff (!rst_n_r)
    speed_r[ACR_URM0_FAST] [*3] |-> o_urm0_tick != $past(o_urm0_tick);
  endproperty
  a_urm0_fast: assert property (p_urm0_fast) // see R13
    else $error("serial mode 0 fast rate wrong");

  property p_ckoe;
    @(posedge i_clk) disable iff (!rst_n_r)
    ##1 o_ctrl.timer0_clock_out_enable == $past(speed_r[ACR_T0_CKOE]) &&
      o_ctrl.timer1_clock_out_enable == $past(speed_r[ACR_T1_CKOE]);
  endproperty
  a_ckoe: assert property (p_ckoe) // see R15
    else $error("timer clock output enable wrong");

  property p_route_pins;
    @(posedge i_clk) disable iff (!rst_n_r)
    ##1 o_ctrl.serial_pin_swap == $past(route_r[ACR_SER_SWAP]) &&
      o_ctrl.pwm_relocate_upper_port == $past(route_r[ACR_PWM_UP]);
  endproperty
  a_route_pins: assert property (p_route_pins) // see R8
    else $error("pin routing outputs wrong");

  property p_fast_drive;
    @(posedge i_clk) disable iff (!rst_n_r)
    ##1 o_ctrl.osc_pin_fast_drive == $past(pinclk_r[ACR_OSC_FD]) &&
      o_ctrl.timer0_pin_fast_drive == $past(pinclk_r[ACR_T0_FD]);
  endproperty
  a_fast_drive: assert property (p_fast_drive) // see R3
    else $error("fast drive outputs wrong");

endmodule // acr_aux_regs
`default_nettype wire

/* acr_pkg.sv */
// Notes on behaviour
// R1: Crystal pin select 00 GPIO, 01 oscillator, 10 oscillator/2, 11 oscillator/4.
// R2: Crystal pin select acts only while internal RC oscillator clocks the system.
// R3: Oscillator pin fast-drive bit set gives strong drive, clear gives default.
// R4: Timer 0 pin fast-drive bit set gives strong drive, clear gives default.
// R5: Expanded RAM disable clear maps on-chip RAM; set disables it.
// R6: Wakeup port select 00 port 0, 01 port 2, 10 port 3, 11 port 5.
// R7: PWM relocate clear uses port 2; set also drives PWM on port 5.
// R8: Serial pin swap clear keeps port 3 pins; set moves to port 1.
// R9: Spare flag two is free read/write storage without side effect.
// R10: Data pointer select 0 picks first pointer, 1 picks second.
// R11: Bit 7 of speed register: timer 0 clock system clock/12 or system clock.
// R12: Timer 1 speed bit: timer 1 clock system clock/12 or system clock.
// R13: Serial mode 0 rate bit: shift clock system clock/12 or /2.
// R14: Timer 1 clock output enable drives timer 1 clock on port 3.5.
// R15: Timer 0 clock output enable drives timer 0 clock on port 3.4.
// R16: All three registers reachable on every page; reset to zero.
// R17: Reserved bits reset to zero, stored, read back, no effect.
package acr_pkg;
  localparam logic [7:0] ACR_SPEED_ADDR = 8'h87;
  localparam logic [7:0] ACR_PINCLK_ADDR = 8'h8E;
  localparam logic [7:0] ACR_ROUTE_ADDR = 8'hA2;
  localparam logic [7:0] ACR_SPEED_RST = 8'h00;
  localparam logic [7:0] ACR_PINCLK_RST = 8'h00;
  localparam logic [7:0] ACR_ROUTE_RST = 8'h00;
  // Clock-pin register fields
  localparam int ACR_XSEL_LO = 6;
  localparam int ACR_OSC_FD = 5;
  localparam int ACR_T0_FD = 4;
  localparam int ACR_ERAM_DIS = 1;
  // Routing register fields
  localparam int ACR_WAKE_LO = 6;
  localparam int ACR_PWM_UP = 5;
  localparam int ACR_SER_SWAP = 4;
  localparam int ACR_SPARE2 = 3;
  localparam int ACR_DP_SEL = 0;
  // Speed register fields and rate dividers
  localparam int ACR_T0_FAST = 7;
  localparam int ACR_T1_FAST = 6;
  localparam int ACR_URM0_FAST = 5;
  localparam int ACR_T1_CKOE = 1;
  localparam int ACR_T0_CKOE = 0;
  localparam int ACR_SLOW_DIV = 12;
  localparam int ACR_URM0_FAST_DIV = 2;
  typedef enum logic [1:0] {
    ACR_X_GPIO = 2'b00,
    ACR_X_OSC = 2'b01,
    ACR_X_DIV2 = 2'b10,
    ACR_X_DIV4 = 2'b11
  } acr_xsel_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acr_sfr_req_t;
  typedef struct packed {
    logic osc_pin_fast_drive;
    logic timer0_pin_fast_drive;
    logic expanded_ram_enable;
    logic [3:0] wake_port_onehot;
    logic pwm_relocate_upper_port;
    logic serial_pin_swap;
    logic data_pointer_select;
    logic timer1_clock_out_enable;
    logic timer0_clock_out_enable;
  } acr_ctrl_t;
endpackage

/* acr_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module acr_cpu_model (
  input wire logic i_clk, // System clock
  output acr_pkg::acr_sfr_req_t o_sfr, // Request to registers
  input wire logic [7:0] i_rdata // Read data
);
  import acr_pkg::*;
  initial o_sfr = '0;
  // One-cycle pulse, launched and released on falling edges
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_sfr = '{rd: rd, wr: ~rd, addr: a, wdata: d};
    @(negedge i_clk);
    // Idle bus shows the inverse, never a stale copy
    o_sfr = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Write then read of one address in back-to-back cycles
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_sfr = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge i_clk);
    o_sfr = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~d};
    @(negedge i_clk);
    o_sfr = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: d};
  endtask
endmodule // acr_cpu_model
`default_nettype wire

/* tb_acr_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import acr_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} acr_row_t;
  localparam acr_row_t ROWS [16] = '{
    '{8'h8E, 8'h20, 8'h20}, '{8'h8E, 8'h10, 8'h10}, '{8'h8E, 8'h02, 8'h02},
    '{8'h8E, 8'h0D, 8'h0D}, '{8'hA2, 8'h40, 8'h40}, '{8'hA2, 8'h80, 8'h80},
    '{8'hA2, 8'hC0, 8'hC0}, '{8'hA2, 8'h20, 8'h20}, '{8'hA2, 8'h10, 8'h10},
    '{8'hA2, 8'h09, 8'h09}, '{8'hA2, 8'h06, 8'h06}, '{8'h87, 8'h02, 8'h02},
    '{8'h87, 8'h01, 8'h01}, '{8'h87, 8'h1C, 8'h1C}, '{8'h88, 8'h55, 8'h00},
    '{8'hA2, 8'h00, 8'h00}};
  localparam logic [7:0] SPV [3] = '{8'h00, 8'hA0, 8'h40};
  localparam logic [7:0] ADRS [3] = '{ACR_SPEED_ADDR, ACR_PINCLK_ADDR, ACR_ROUTE_ADDR};
  logic clk, nrst, rc, osc, gpo, gpoe, t0m, t1m, xo, xoe, xrole, t0t, t1t, urt, prev;
  acr_sfr_req_t sfr;
  acr_ctrl_t ctrl;
  logic [7:0] rdata, q, pk, rt, sp;
  int error_cnt, checked, a, b, c, n;
  acr_cpu_model u_cpu (.i_clk(clk), .o_sfr(sfr), .i_rdata(rdata));
  acr_aux_regs #(.SLOW_DIV(12)) u_dut (
    .i_clk(clk), .i_nrst(nrst), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .i_rc_is_sys_clock(rc), .i_osc_tick(osc), .i_gpio_o(gpo), .i_gpio_oe(gpoe),
    .i_t0_timer_mode(t0m), .i_t1_timer_mode(t1m), .o_xtal_pin_o(xo),
    .o_xtal_pin_oe(xoe), .o_xtal_osc_role(xrole), .o_ctrl(ctrl),
    .o_t0_tick(t0t), .o_t1_tick(t1t), .o_urm0_tick(urt));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    u_cpu.xfer(1'b0, ad, d);
    if (ad == ACR_PINCLK_ADDR) pk = d;
    if (ad == ACR_ROUTE_ADDR) rt = d;
    if (ad == ACR_SPEED_ADDR) sp = d;
  endtask
  task automatic rd(input logic [7:0] ad);
    u_cpu.xfer(1'b1, ad, 8'h00);
    q = rdata;
  endtask
  task automatic do_reset();
    @(negedge clk);
    nrst = 1'b0;
    wt(16);
    nrst = 1'b1;
    wt(3);
    {pk, rt, sp} = '0;
  endtask
  function automatic acr_ctrl_t exp_ctrl();
    acr_ctrl_t e;
    e.osc_pin_fast_drive = pk[ACR_OSC_FD];
    e.timer0_pin_fast_drive = pk[ACR_T0_FD];
    e.expanded_ram_enable = ~pk[ACR_ERAM_DIS];
    e.wake_port_onehot = 4'h1 << rt[ACR_WAKE_LO +: 2];
    e.pwm_relocate_upper_port = rt[ACR_PWM_UP];
    e.serial_pin_swap = rt[ACR_SER_SWAP];
    e.data_pointer_select = rt[ACR_DP_SEL];
    e.timer1_clock_out_enable = sp[ACR_T1_CKOE];
    e.timer0_clock_out_enable = sp[ACR_T0_CKOE];
    return e;
  endfunction
  task automatic count(input int k);
    {a, b, c} = '0;
    repeat (k)
    begin
      @(negedge clk);
      a += t0t;
      b += t1t;
      c += urt;
    end
  endtask
  initial
  begin
    {rc, osc, gpo, gpoe, t0m, t1m} = '0;
    nrst = 1'b0;
    error_cnt = 0;
    checked = 0;
    do_reset();
    foreach (ADRS[i])
    begin
      rd(ADRS[i]);
      chk(q, 8'h00);
    end
    chk(ctrl, exp_ctrl());
    foreach (ROWS[i])
    begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a);
      chk(q, ROWS[i].q);
      chk(ctrl, exp_ctrl());
    end
    u_cpu.wr_rd(ACR_ROUTE_ADDR, 8'h5A);
    rt = 8'h5A;
    chk(rdata, 8'h5A);
    {t0m, t1m} = 2'b11;
    foreach (SPV[i])
    begin
      wr(ACR_SPEED_ADDR, SPV[i]);
      wt(4);
      count(24);
      chk(a, SPV[i][7] ? 24 : 2);
      chk(b, SPV[i][6] ? 24 : 2);
      chk(c, SPV[i][5] ? 12 : 2);
    end
    wr(ACR_SPEED_ADDR, 8'hE0);
    {t0m, t1m} = 2'b00;
    wt(4);
    count(24);
    chk(a, 0);
    chk(b, 0);
    {rc, osc, gpo, gpoe} = 4'hF;
    wr(ACR_PINCLK_ADDR, 8'h00);
    wt(4);
    chk({xo, xoe, xrole}, 3'b110);
    gpo = 1'b0;
    wt(3);
    chk({xo, xoe, xrole}, 3'b010);
    for (int m = 1; m < 4; m++)
    begin
      wr(ACR_PINCLK_ADDR, 8'(m << 6));
      wt(4);
      n = 0;
      prev = xo;
      repeat (32)
      begin
        @(negedge clk);
        n += int'(xo !== prev);
        prev = xo;
      end
      chk(n, 32 >> (m - 1));
      chk(xoe, 1'b1);
    end
    rc = 1'b0;
    wt(4);
    chk({xo, xoe, xrole}, 3'b001);
    wr(ACR_ROUTE_ADDR, 8'hFF);
    do_reset();
    rd(ACR_ROUTE_ADDR);
    chk(q, 8'h00);
    chk(ctrl, exp_ctrl());
    tally_and_finish();
  end
  // Whole run is under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
